// [inc/igv_pkg.sv]
package igv_pkg;

  // register bus geometry: byte address is four times the index
  localparam int          ADDR_W         = 8;
  localparam logic [5:0]  IDX_VOL3       = 6'h22;
  localparam logic [5:0]  IDX_AMP0       = 6'h23;
  localparam logic [5:0]  IDX_AMP1       = 6'h24;
  localparam logic [5:0]  IDX_AMP2       = 6'h25;
  localparam logic [5:0]  IDX_AMP3       = 6'h26;
  localparam logic [5:0]  IDX_RAMP_STAT  = 6'h30;
  localparam logic [5:0]  IDX_GAIN_STAT  = 6'h31;

  // reset values
  localparam logic [7:0]  RST_VOL3       = 8'h00;
  localparam logic [7:0]  RST_AMP        = 8'h40;

  // field positions of an amplifier control byte
  localparam int          AMP_MIC_BIT    = 7;
  localparam int          AMP_MUTE_BIT   = 6;
  localparam int          AMP_GAIN_LSB   = 0;
  localparam int          AMP_GAIN_W     = 6;
  localparam int          NUM_AMPS       = 4;

  // ramp status field position
  localparam int          STAT_BUSY_BIT  = 8;

  // volume codes: 0.375 dB attenuation per code, all ones is the floor
  localparam logic [7:0]  VOL_MAX_ATTEN  = 8'hFF;
  localparam logic [5:0]  GAIN_MIN       = 6'h00;
  localparam int          RAMP_FS_STEP   = 16;
  localparam logic [3:0]  RAMP_CNT_LAST  = 4'(RAMP_FS_STEP - 1);

  // gain slew times over the full gain span, and derived step periods
  localparam int          CLK_MHZ        = 125;
  localparam int          GAIN_CODES     = 64;
  localparam int          SLEW_FAST_US   = 21500;
  localparam int          SLEW_MID_US    = 42500;
  localparam int          SLEW_SLOW_US   = 85000;
  localparam int          SLEW_FAST_CYC  = SLEW_FAST_US * CLK_MHZ / GAIN_CODES;
  localparam int          SLEW_MID_CYC   = SLEW_MID_US * CLK_MHZ / GAIN_CODES;
  localparam int          SLEW_SLOW_CYC  = SLEW_SLOW_US * CLK_MHZ / GAIN_CODES;

  typedef enum logic [1:0] {SLEW_FAST, SLEW_MID, SLEW_SLOW, SLEW_RSVD} igv_slew_rate_t;

  typedef struct packed {
    logic       mic_en;
    logic       mute;
    logic [5:0] gain;
  } igv_amp_ctrl_t;

  typedef struct packed {
    logic       powered;
    logic       mute;
    logic       invert;
    logic [5:0] gain;
  } igv_amp_out_t;

  // one code toward the target, holding once there
  function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] tgt);
    if (cur < tgt)
      step_toward = cur + 8'h01;
    else if (cur > tgt)
      step_toward = cur - 8'h01;
    else
      step_toward = cur;
  endfunction

endpackage

// [src/igv_gain_slew.sv]
`timescale 1ns/1ns
module igv_gain_slew #(
  parameter int CNT_W    = 18,
  parameter int FAST_CYC = igv_pkg::SLEW_FAST_CYC,
  parameter int MID_CYC  = igv_pkg::SLEW_MID_CYC,
  parameter int SLOW_CYC = igv_pkg::SLEW_SLOW_CYC
)
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire igv_pkg::igv_amp_ctrl_t ctrl,
  input  wire logic [1:0]            slew_rate,
  input  wire logic                  slew_disable,
  output igv_pkg::igv_amp_out_t      amp_out
);

  typedef struct packed {
    logic [CNT_W-1:0]      cnt;
    igv_pkg::igv_amp_out_t out;
  } igv_slew_state_t;

  igv_slew_state_t  s_reg;
  igv_slew_state_t  s_next;
  logic [CNT_W-1:0] last;

  // step period from the selected rate; the spare code takes the slowest
  always_comb
  begin
    unique case (igv_pkg::igv_slew_rate_t'(slew_rate))
      igv_pkg::SLEW_FAST: last = CNT_W'(FAST_CYC - 1);
      igv_pkg::SLEW_MID:  last = CNT_W'(MID_CYC - 1);
      igv_pkg::SLEW_SLOW: last = CNT_W'(SLOW_CYC - 1);
      igv_pkg::SLEW_RSVD: last = CNT_W'(SLOW_CYC - 1);
    endcase
  end

  // amplifier power, mute, inversion and slewed gain
  always_comb
  begin
    s_next             = s_reg;
    s_next.out.powered = ctrl.mic_en;
    s_next.out.mute    = ctrl.mute;
    s_next.out.invert  = ctrl.mic_en;
    if (!ctrl.mic_en)
    begin
      s_next.out.gain = igv_pkg::GAIN_MIN;
      s_next.cnt      = '0;
    end
    else if (ctrl.mute)
      s_next.cnt = '0;
    else if (slew_disable)
    begin
      s_next.out.gain = ctrl.gain;
      s_next.cnt      = '0;
    end
    else if (s_reg.out.gain == ctrl.gain)
      s_next.cnt = '0;
    else if (s_reg.cnt >= last)
    begin
      s_next.cnt      = '0;
      s_next.out.gain = 6'(igv_pkg::step_toward({2'b00, s_reg.out.gain}, {2'b00, ctrl.gain}));
    end
    else
      s_next.cnt = s_reg.cnt + CNT_W'(1);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      s_reg <= '{cnt: '0, out: '{powered: 1'b0, mute: 1'b1, invert: 1'b0, gain: 6'h00}};
    else
      s_reg <= s_next;
  end

  assign amp_out = s_reg.out;

endmodule // igv_gain_slew

// [src/igv_top.sv]
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
module igv_top #(
  parameter int SLEW_CNT_W    = 18,
  parameter int SLEW_FAST_CYC = igv_pkg::SLEW_FAST_CYC,
  parameter int SLEW_MID_CYC  = igv_pkg::SLEW_MID_CYC,
  parameter int SLEW_SLOW_CYC = igv_pkg::SLEW_SLOW_CYC
)
(
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [igv_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         sample_tick,
  input  wire logic                         decimator3_enable,
  input  wire logic [1:0]                   slew_rate,
  input  wire logic [3:0]                   slew_disable,
  output logic      [7:0]                   channel3_volume_applied,
  output logic                              channel3_ramp_busy,
  output igv_pkg::igv_amp_out_t [3:0]       amp_out
);

  typedef struct packed {
    logic [7:0]                   channel3_volume_code;
    igv_pkg::igv_amp_ctrl_t [3:0] amp;
    logic [31:0]                  rdata;
    logic                         ready;
    logic                         slverr;
  } igv_top_state_t;

  igv_top_state_t s_reg;
  igv_top_state_t s_next;
  logic [7:0]     vol_applied;
  logic           vol_busy;
  logic [5:0]     idx;
  logic           setup;
  logic           access;

  // bus phases; index is the word address
  assign idx    = paddr[igv_pkg::ADDR_W-1:2];
  assign setup  = psel && !penable;
  assign access = psel && penable && s_reg.ready;

  // address decode shared by read and write paths
  function automatic logic addr_hit(input logic [igv_pkg::ADDR_W-1:0] a);
    logic [5:0] i;
    i = a[igv_pkg::ADDR_W-1:2];
    addr_hit = (a[1:0] == 2'b00) &&
               ((i == igv_pkg::IDX_VOL3) || (i == igv_pkg::IDX_AMP0) ||
                (i == igv_pkg::IDX_AMP1) || (i == igv_pkg::IDX_AMP2) ||
                (i == igv_pkg::IDX_AMP3) || (i == igv_pkg::IDX_RAMP_STAT) ||
                (i == igv_pkg::IDX_GAIN_STAT));
  endfunction

  // register file and apb slave
  always_comb
  begin
    s_next        = s_reg;
    s_next.ready  = 1'b0;
    s_next.slverr = 1'b0;
    // setup cycle: latch read data and error, answer in the access cycle
    if (setup)
    begin
      s_next.ready  = 1'b1;
      s_next.slverr = !addr_hit(paddr);
      s_next.rdata  = 32'h0000_0000;
      if (addr_hit(paddr))
      begin
        unique case (idx)
          igv_pkg::IDX_VOL3:      s_next.rdata[7:0] = s_reg.channel3_volume_code;
          igv_pkg::IDX_AMP0:      s_next.rdata[7:0] = s_reg.amp[0];
          igv_pkg::IDX_AMP1:      s_next.rdata[7:0] = s_reg.amp[1];
          igv_pkg::IDX_AMP2:      s_next.rdata[7:0] = s_reg.amp[2];
          igv_pkg::IDX_AMP3:      s_next.rdata[7:0] = s_reg.amp[3];
          igv_pkg::IDX_RAMP_STAT:
          begin
            s_next.rdata[7:0]                    = vol_applied;
            s_next.rdata[igv_pkg::STAT_BUSY_BIT] = vol_busy;
          end
          igv_pkg::IDX_GAIN_STAT:
          begin
            for (int k = 0; k < igv_pkg::NUM_AMPS; k++)
              s_next.rdata[k*6 +: 6] = amp_out[k].gain;
          end
          default:                s_next.rdata = 32'h0000_0000;
        endcase
      end
    end
    // access cycle: writes land on the completing edge, low byte lane only
    if (access && pwrite && !s_reg.slverr && pstrb[0])
    begin
      unique case (idx)
        igv_pkg::IDX_VOL3: s_next.channel3_volume_code = pwdata[7:0];
        igv_pkg::IDX_AMP0: s_next.amp[0] = pwdata[7:0];
        igv_pkg::IDX_AMP1: s_next.amp[1] = pwdata[7:0];
        igv_pkg::IDX_AMP2: s_next.amp[2] = pwdata[7:0];
        igv_pkg::IDX_AMP3: s_next.amp[3] = pwdata[7:0];
        default:           s_next.rdata  = s_reg.rdata;
      endcase
    end
  end

  // synchronous reset of all registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_reg.channel3_volume_code <= igv_pkg::RST_VOL3;
      for (int k = 0; k < igv_pkg::NUM_AMPS; k++)
        s_reg.amp[k] <= igv_pkg::RST_AMP;
      s_reg.rdata  <= 32'h0000_0000;
      s_reg.ready  <= 1'b0;
      s_reg.slverr <= 1'b0;
    end
    else
      s_reg <= s_next;
  end

  igv_vol_ramp u_ramp
  (
    .clock       (clock),
    .rst_n       (rst_n),
    .sample_tick (sample_tick),
    .decim_en    (decimator3_enable),
    .target      (s_reg.channel3_volume_code),
    .applied     (vol_applied),
    .busy        (vol_busy)
  );

  // one slew engine per amplifier
  for (genvar g = 0; g < igv_pkg::NUM_AMPS; g++)
  begin : g_amp
    igv_gain_slew #(
      .CNT_W    (SLEW_CNT_W),
      .FAST_CYC (SLEW_FAST_CYC),
      .MID_CYC  (SLEW_MID_CYC),
      .SLOW_CYC (SLEW_SLOW_CYC)
    ) u_slew
    (
      .clock        (clock),
      .rst_n        (rst_n),
      .ctrl         (s_reg.amp[g]),
      .slew_rate    (slew_rate),
      .slew_disable (slew_disable[g]),
      .amp_out      (amp_out[g])
    );
  end

  assign prdata                  = s_reg.rdata;
  assign pready                  = s_reg.ready;
  assign pslverr                 = s_reg.slverr;
  assign channel3_volume_applied = vol_applied;
  assign channel3_ramp_busy      = vol_busy;

endmodule // igv_top

// [src/igv_vol_ramp.sv]
`timescale 1ns/1ns
module igv_vol_ramp
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       sample_tick,
  input  wire logic       decim_en,
  input  wire logic [7:0] target,
  output logic      [7:0] applied,
  output logic            busy
);

  typedef struct packed {
    logic [7:0] vol;
    logic [3:0] cnt;
    logic       en_d;
    logic       busy;
  } igv_ramp_state_t;

  igv_ramp_state_t s_reg;
  igv_ramp_state_t s_next;

  // ramp sequencing
  always_comb
  begin
    s_next      = s_reg;
    s_next.en_d = decim_en;
    if (!decim_en)
    begin
      s_next.vol = igv_pkg::VOL_MAX_ATTEN;
      s_next.cnt = 4'h0;
    end
    else if (!s_reg.en_d)
    begin
      s_next.vol = igv_pkg::VOL_MAX_ATTEN;
      s_next.cnt = 4'h0;
    end
    else if (s_reg.vol == target)
      s_next.cnt = 4'h0;
    else if (sample_tick)
    begin
      if (s_reg.cnt == igv_pkg::RAMP_CNT_LAST)
      begin
        s_next.cnt = 4'h0;
        s_next.vol = igv_pkg::step_toward(s_reg.vol, target);
      end
      else
        s_next.cnt = s_reg.cnt + 4'h1;
    end
    s_next.busy = decim_en && (s_next.vol != target);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      s_reg <= '{vol: igv_pkg::VOL_MAX_ATTEN, cnt: 4'h0, en_d: 1'b0, busy: 1'b0};
    else
      s_reg <= s_next;
  end

  assign applied = s_reg.vol;
  assign busy    = s_reg.busy;

endmodule // igv_vol_ramp

// [verif/igv_top_sva.sv]
`timescale 1ns/1ns
module igv_top_sva
(
  input wire logic                        clock,
  input wire logic                        rst_n,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic [igv_pkg::ADDR_W-1:0]  paddr,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        decimator3_enable,
  input wire logic [3:0]                  slew_disable,
  input wire logic [7:0]                  channel3_volume_applied,
  input wire igv_pkg::igv_amp_out_t [3:0] amp_out
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // bus phases
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence

  // bus answer and refusal
  bus_answer_a: assert property (setup_s |=> pready)
    else $error("access phase not answered");
  ready_pulse_a: assert property (access_s |=> !pready)
    else $error("ready held too long");
  bad_align_a: assert property (setup_s and paddr[1:0] != 2'h0 |=> pslverr)
    else $error("unaligned access not refused");

  // channel-3 volume ramp
  vol_floor_a: assert property (!decimator3_enable [*3] |-> channel3_volume_applied == 8'hFF)
    else $error("volume not at floor while disabled");
  vol_step_a: assert property (decimator3_enable && $past(decimator3_enable)
    && $past(decimator3_enable, 2) |-> (channel3_volume_applied
    - $past(channel3_volume_applied)) inside {8'h00, 8'h01, 8'hFF})
    else $error("volume moved more than one code");

  // amplifier outputs
  invert_power_a: assert property (amp_out[0].invert == amp_out[0].powered)
    else $error("inversion differs from power");
  line_gain_a: assert property (!amp_out[1].powered [*2] |-> amp_out[1].gain == 6'h00)
    else $error("line input with nonzero gain");
  slew_step_a: assert property (!slew_disable[2] && !$past(slew_disable[2])
    && amp_out[2].powered && $past(amp_out[2].powered)
    |-> (amp_out[2].gain - $past(amp_out[2].gain)) inside {6'h00, 6'h01, 6'h3F})
    else $error("gain jumped while slewing");
  mute_freeze_a: assert property ((amp_out[3].mute && amp_out[3].powered) [*3]
    |-> $past(amp_out[3].gain) == $past(amp_out[3].gain, 2))
    else $error("muted gain moved");
endmodule // igv_top_sva

bind igv_top igv_top_sva i_igv_top_sva
(
  .clock(clock),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .pready(pready),
  .pslverr(pslverr),
  .decimator3_enable(decimator3_enable),
  .slew_disable(slew_disable),
  .channel3_volume_applied(channel3_volume_applied),
  .amp_out(amp_out)
);

// [verif/tb_igv_top.sv]
`timescale 1ns/1ns
module tb_igv_top;
  logic                        clock = 1'b0;
  logic                        rst_n = 1'b0;
  logic                        psel = 1'b0;
  logic                        penable = 1'b0;
  logic                        pwrite = 1'b0;
  logic [7:0]                  paddr = 8'h00;
  logic [31:0]                 pwdata = 32'h0;
  logic [3:0]                  pstrb = 4'h0;
  logic [31:0]                 prdata;
  logic                        pready;
  logic                        pslverr;
  logic                        sample_tick = 1'b0;
  logic                        decimator3_enable = 1'b0;
  logic [1:0]                  slew_rate = 2'h0;
  logic [3:0]                  slew_disable = 4'hF;
  logic [7:0]                  vol;
  logic                        busy;
  igv_pkg::igv_amp_out_t [3:0] amp_out;
  logic [31:0]                 rd;
  logic                        err;
  int                          err_total = 0;
  int                          check_count = 0;
  int                          n;
  int                          per[4] = '{4, 8, 16, 16};
  logic [7:0]                  ampv[4] = '{8'h80, 8'h90, 8'hBF, 8'h81};

  igv_top #(.SLEW_FAST_CYC(4), .SLEW_MID_CYC(8), .SLEW_SLOW_CYC(16)) i_igv_top
  (
    .clock(clock),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .sample_tick(sample_tick),
    .decimator3_enable(decimator3_enable),
    .slew_rate(slew_rate),
    .slew_disable(slew_disable),
    .channel3_volume_applied(vol),
    .channel3_ramp_busy(busy),
    .amp_out(amp_out)
  );

  // 125 MHz clock
  always #4 clock = ~clock;

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high, then one idle edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int k;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      err_total++;
      give_verdict();
    end
    // idle edge so a following call never re-drives psel in this step
    @(posedge clock);
  endtask

  // sample-rate pulses
  task automatic tick(input int c);
    repeat (c)
    begin
      sample_tick <= 1'b1;
      @(posedge clock);
      sample_tick <= 1'b0;
      @(posedge clock);
    end
    @(posedge clock);
  endtask

  initial
  begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    // reset values, then each amplifier written and read back
    apb(0, 8'h88, 0, 0); check(rd, 32'h00);
    for (int i = 0; i < 4; i++)
    begin
      apb(0, 8'h8C + 8'(4 * i), 0, 0); check(rd, 32'h40);
      apb(1, 8'h8C + 8'(4 * i), 32'(ampv[i]), 4'h1);
    end
    repeat (4) @(posedge clock);
    for (int i = 0; i < 4; i++)
    begin
      apb(0, 8'h8C + 8'(4 * i), 0, 0); check(rd, 32'(ampv[i]));
      check(32'(amp_out[i]), 32'({3'b101, ampv[i][5:0]}));
    end
    // refusals: unmapped, unaligned, strobe off
    apb(1, 8'h9C, 32'hFF, 4'hF); check(32'(err), 1);
    apb(0, 8'h89, 0, 0); check(32'(err), 1);
    apb(1, 8'h88, 32'h55, 4'h0); apb(0, 8'h88, 0, 0); check(rd, 32'h00);
    // mute freezes the applied gain
    slew_disable <= 4'h0;
    apb(1, 8'h8C, 32'hC9, 4'h1);
    repeat (40) @(posedge clock);
    check(32'(amp_out[0]), 32'({3'b111, 6'h00}));
    // every slew rate code, four codes each, up and down in turn
    for (int r = 0; r < 4; r++)
    begin
      slew_rate <= 2'(r);
      apb(1, 8'h8C, (r % 2) ? 32'h80 : 32'h84, 4'h1);
      n = 0;
      while (amp_out[0].gain !== ((r % 2) ? 6'h00 : 6'h04) && n < 500)
      begin
        @(posedge clock);
        n++;
      end
      check(32'(n >= 4 * per[r] - 1 && n <= 4 * per[r] + 4), 1);
    end
    // line mode powers down and clears gain
    apb(1, 8'h8C, 32'h3F, 4'h1);
    repeat (4) @(posedge clock);
    check(32'(amp_out[0]), 32'h0);
    // gain status: amp k gain at six bits per amp
    apb(0, 8'hC4, 0, 0);
    check(rd, {8'h00, ampv[3][5:0], ampv[2][5:0], ampv[1][5:0], 6'h00});
    // full ramp from the floor to 0 dB; converter enable assumed paired
    decimator3_enable <= 1'b1;
    repeat (3) @(posedge clock);
    check(32'(vol), 32'hFF);
    check(32'(busy), 1);
    tick(15); check(32'(vol), 32'hFF);
    tick(1); check(32'(vol), 32'hFE);
    n = 16;
    while (vol !== 8'h00 && n < 5000)
    begin
      tick(1);
      n++;
    end
    check(32'(n), 32'd4080);
    tick(40); check(32'(vol), 32'h00); check(32'(busy), 0);
    // new target after the ramp has settled, then read status
    apb(1, 8'h88, 32'h02, 4'h1);
    tick(32); check(32'(vol), 32'h02);
    apb(0, 8'hC0, 0, 0); check(rd, 32'h02);
    decimator3_enable <= 1'b0;
    repeat (3) @(posedge clock);
    check(32'(vol), 32'hFF);
    give_verdict();
  end
endmodule // tb_igv_top
